// ==== hdl/cardbus_socket_regs.vh ====
// Constants for the CardBus socket control block.
// Assumes inclusion by the socket control file only.
`ifndef CARDBUS_SOCKET_REGS_VH
`define CARDBUS_SOCKET_REGS_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 100
`define DEVSEL_TIMEOUT_CYC 5
`define PERR_DELAY_CYC 2

// ----------------------------------------
// Bus commands and encodings
// ----------------------------------------
`define CMD_SPECIAL 4'h1
`define BE_ALL 4'h0

// ----------------------------------------
// Initiator states
// ----------------------------------------
`define I_IDLE 2'h0
`define I_ADDR 2'h1
`define I_DATA 2'h2
`define I_TURN 2'h3

// ----------------------------------------
// Target states
// ----------------------------------------
`define T_IDLE 2'h0
`define T_DATA 2'h1
`define T_TURN 2'h2

// ----------------------------------------
// FIFO word layout: {last, be[3:0], data[31:0]}
// ----------------------------------------
`define FW_LAST 36
`define FW_BE_HI 35
`define FW_BE_LO 32
`define FW_WIDTH 37

`endif

// ==== hdl/cardbus_socket_control.v ====
// CardBus socket control signals of a host bridge, plus its write-data FIFO.
// Assumes all socket inputs are synchronous to clk (the CardBus clock) and
// that address decode and the wide datapath sit outside this block.
`timescale 1ns/1ns
`default_nettype none
`include "cardbus_socket_regs.vh"

// ----------------------------------------
// Data FIFO
// ----------------------------------------
module sock_fifo #(
  parameter WIDTH = 37,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  input wire ce,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr;
  reg [AW:0] rd_ptr;
  wire [AW:0] fill;
  wire push;
  wire pop;

  // Extra pointer bit tells full from empty
  assign fill = wr_ptr - rd_ptr;
  assign in_ready = (fill != DEPTH[AW:0]);
  assign out_valid = (fill != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointers and storage
  always @(posedge clk) begin
    if (!rst_b) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else if (ce) begin
      if (push) begin
        mem[wr_ptr[AW-1:0]] <= in_data;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule // sock_fifo

// ----------------------------------------
// Socket control
// ----------------------------------------
// Summary of operation
// - Data phase completes only on an edge with ready from both initiator and target.
// - Initiator holds frame asserted from start while more data words follow.
// - Frame released marks the current data phase as the final one.
// - As target the bridge asserts device select to claim a decoded cycle.
// - As initiator, no device select before timeout ends the cycle with abort.
// - A target may assert stop to end or disconnect the transaction.
// - Target drives parity error low two clocks after the failing data cycle.
// - Parity error reporting covers every transaction the bridge is target of, except special cycles.
// - Grant is given to the card only once the current transaction is done.
// - System error releases slowly through a pull-up; only new assertions count.
// - A card system error is forwarded to the host system error output.
// - Binary card audio passes through to the speaker output.
// - Status change raises an alert and serves as a wake-up request.
// - Detect and voltage sense pins together give presence, voltage and card type.
// - Lock gives an initiator exclusive access to a target.
// - Even parity over data and command lines; driven one clock later, checked as target.
// - Command lines carry command in address phase, active-low byte enables in data.
module cardbus_socket_control #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  // Clock, reset, enable
  input wire clk,
  input wire rst_b,
  input wire ce,
  // Host initiator requests
  input wire ini_start,
  input wire [3:0] ini_cmd,
  input wire [31:0] ini_addr,
  input wire ini_write,
  input wire ini_lock,
  output wire ini_busy,
  output reg ini_done,
  output reg ini_abort,
  output reg ini_stopped,
  // Host data words {last, be, data}
  input wire wd_valid,
  output wire wd_ready,
  input wire [36:0] wd_data,
  output reg rd_valid,
  output reg [31:0] rd_data,
  // Host target side
  input wire tgt_hit,
  input wire tgt_ready,
  input wire tgt_disconnect,
  output reg tgt_active,
  // Socket address/data and command lines
  input wire [31:0] cad_in,
  output reg [31:0] cad_out,
  output reg cad_oe,
  input wire [3:0] cbe_in,
  output reg [3:0] cbe_out,
  output reg cbe_oe,
  input wire cpar_in,
  output reg cpar_out,
  output reg cpar_oe,
  // Socket control lines, active low
  input wire cframe_b_in,
  output reg cframe_b_out,
  output reg cframe_oe,
  input wire cirdy_b_in,
  output reg cirdy_b_out,
  output reg cirdy_oe,
  input wire ctrdy_b_in,
  output reg ctrdy_b_out,
  output reg ctrdy_oe,
  input wire cdevsel_b_in,
  output reg cdevsel_b_out,
  output reg cdevsel_oe,
  input wire cstop_b_in,
  output reg cstop_b_out,
  output reg cstop_oe,
  input wire cperr_b_in,
  output reg cperr_b_out,
  output reg cperr_oe,
  input wire cblock_b_in,
  output reg cblock_b_out,
  output reg cblock_oe,
  // Arbitration
  input wire creq_b,
  output reg cgnt_b,
  // Card events and sense
  input wire cserr_b,
  input wire cint_b,
  input wire caudio,
  input wire cstschg,
  input wire ccd1_b,
  input wire ccd2_b,
  input wire cvs1_in,
  output reg cvs1_out,
  output reg cvs1_oe,
  input wire cvs2_in,
  output reg cvs2_out,
  output reg cvs2_oe,
  // Host-side outputs
  output reg serr_b,
  output reg card_irq,
  output reg speaker_out,
  output reg stschg_alert,
  output reg wake_req,
  output reg card_present,
  output reg [1:0] card_volt,
  output reg card_is_cardbus
);
  reg [1:0] ini_state;
  reg [1:0] tgt_state;
  reg [2:0] to_cnt;
  reg lock_held;
  reg frame_q;
  reg [3:0] tgt_cmd;
  reg par_calc;
  reg chk_pend;
  reg [`PERR_DELAY_CYC-1:0] perr_pipe;
  reg cserr_q;
  reg stschg_q;
  wire bus_idle;
  wire head_valid;
  wire head_pop;
  wire [36:0] head;
  wire phase_done;
  wire addr_phase;

  // Socket is free once frame and initiator ready are both released
  assign bus_idle = cframe_b_in && cirdy_b_in;
  assign ini_busy = (ini_state != `I_IDLE);
  assign phase_done = !cirdy_b_in && !ctrdy_b_in;
  assign addr_phase = frame_q && !cframe_b_in;
  // A word leaves the FIFO only when its data phase really completes
  assign head_pop = (ini_state == `I_DATA) && phase_done && !cdevsel_b_in;

  sock_fifo #(
    .WIDTH(`FW_WIDTH),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .in_valid(wd_valid),
    .in_ready(wd_ready),
    .in_data(wd_data),
    .out_valid(head_valid),
    .out_ready(head_pop),
    .out_data(head)
  );

  // ----------------------------------------
  // Initiator engine
  // ----------------------------------------
  // Empty FIFO holds ready off, so the host stalls the data phase
  always @(posedge clk) begin
    if (!rst_b) begin
      ini_state <= `I_IDLE;
      to_cnt <= 3'h0;
      ini_done <= 1'b0;
      ini_abort <= 1'b0;
      ini_stopped <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 32'h0;
      cframe_b_out <= 1'b1;
      cframe_oe <= 1'b0;
      cirdy_b_out <= 1'b1;
      cirdy_oe <= 1'b0;
      cad_out <= 32'h0;
      cad_oe <= 1'b0;
      cbe_out <= 4'h0;
      cbe_oe <= 1'b0;
    end else if (ce) begin
      ini_done <= 1'b0;
      ini_abort <= 1'b0;
      ini_stopped <= 1'b0;
      rd_valid <= 1'b0;
      case (ini_state)
        `I_IDLE: begin
          // No start while the card holds the grant
          if (ini_start && bus_idle && cgnt_b) begin
            ini_state <= `I_ADDR;
            cframe_b_out <= 1'b0;
            cframe_oe <= 1'b1;
            cad_out <= ini_addr;
            cad_oe <= 1'b1;
            cbe_out <= ini_cmd;
            cbe_oe <= 1'b1;
          end else begin
            cframe_oe <= 1'b0;
            cirdy_oe <= 1'b0;
            cad_oe <= 1'b0;
            cbe_oe <= 1'b0;
          end
        end
        `I_ADDR: begin
          ini_state <= `I_DATA;
          to_cnt <= 3'h0;
          cirdy_oe <= 1'b1;
          cirdy_b_out <= !head_valid;
          cframe_b_out <= head_valid && head[`FW_LAST];
          cbe_out <= head_valid ? head[`FW_BE_HI:`FW_BE_LO] : `BE_ALL;
          cad_out <= head[31:0];
          cad_oe <= ini_write;
        end
        `I_DATA: begin
          if (cdevsel_b_in && to_cnt == `DEVSEL_TIMEOUT_CYC - 1) begin
            ini_state <= `I_TURN;
            ini_abort <= 1'b1;
            cframe_b_out <= 1'b1;
            cirdy_b_out <= 1'b1;
          end else if (!cdevsel_b_in && !cstop_b_in) begin
            ini_state <= `I_TURN;
            ini_stopped <= 1'b1;
            cframe_b_out <= 1'b1;
            cirdy_b_out <= 1'b1;
          end else if (head_pop && head[`FW_LAST]) begin
            ini_state <= `I_TURN;
            ini_done <= 1'b1;
            cirdy_b_out <= 1'b1;
          end else begin
            if (cdevsel_b_in) begin
              to_cnt <= to_cnt + 3'h1;
            end
            // Popped word still sits at the head here, so ready drops for one cycle
            cirdy_b_out <= !head_valid || head_pop;
            cframe_b_out <= head_valid && head[`FW_LAST];
            cbe_out <= head_valid ? head[`FW_BE_HI:`FW_BE_LO] : `BE_ALL;
            cad_out <= head[31:0];
          end
          // Card data captured on each completed read phase
          if (head_pop && !ini_write) begin
            rd_valid <= 1'b1;
            rd_data <= cad_in;
          end
        end
        `I_TURN: begin
          // One cycle driving high before letting the pull-ups hold
          ini_state <= `I_IDLE;
          cframe_oe <= 1'b0;
          cirdy_oe <= 1'b0;
          cad_oe <= 1'b0;
          cbe_oe <= 1'b0;
        end
        default: begin
          ini_state <= `I_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Target engine
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst_b) begin
      tgt_state <= `T_IDLE;
      tgt_active <= 1'b0;
      tgt_cmd <= 4'h0;
      frame_q <= 1'b1;
      cdevsel_b_out <= 1'b1;
      cdevsel_oe <= 1'b0;
      ctrdy_b_out <= 1'b1;
      ctrdy_oe <= 1'b0;
      cstop_b_out <= 1'b1;
      cstop_oe <= 1'b0;
    end else if (ce) begin
      frame_q <= cframe_b_in;
      case (tgt_state)
        `T_IDLE: begin
          cdevsel_oe <= 1'b0;
          ctrdy_oe <= 1'b0;
          cstop_oe <= 1'b0;
          if (addr_phase && !ini_busy && tgt_hit) begin
            tgt_state <= `T_DATA;
            tgt_active <= 1'b1;
            tgt_cmd <= cbe_in;
            cdevsel_b_out <= 1'b0;
            cdevsel_oe <= 1'b1;
            ctrdy_oe <= 1'b1;
            ctrdy_b_out <= !tgt_ready;
            cstop_oe <= 1'b1;
            cstop_b_out <= !tgt_disconnect;
          end
        end
        `T_DATA: begin
          // Final phase done once frame is released
          if (phase_done && cframe_b_in) begin
            tgt_state <= `T_TURN;
            cdevsel_b_out <= 1'b1;
            ctrdy_b_out <= 1'b1;
            cstop_b_out <= 1'b1;
          end else begin
            ctrdy_b_out <= !tgt_ready;
            cstop_b_out <= !tgt_disconnect;
          end
        end
        `T_TURN: begin
          tgt_state <= `T_IDLE;
          tgt_active <= 1'b0;
          cdevsel_oe <= 1'b0;
          ctrdy_oe <= 1'b0;
          cstop_oe <= 1'b0;
        end
        default: begin
          tgt_state <= `T_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Parity generate and check
  // ----------------------------------------
  // Checked phase at edge N, its parity at N+1, report from edge N+2
  always @(posedge clk) begin
    if (!rst_b) begin
      cpar_out <= 1'b0;
      cpar_oe <= 1'b0;
      par_calc <= 1'b0;
      chk_pend <= 1'b0;
      perr_pipe <= {`PERR_DELAY_CYC{1'b0}};
      cperr_b_out <= 1'b1;
      cperr_oe <= 1'b0;
    end else if (ce) begin
      cpar_out <= ^{cad_out, cbe_out};
      cpar_oe <= cad_oe;
      par_calc <= ^{cad_in, cbe_in};
      chk_pend <= (tgt_state == `T_DATA) && phase_done
        && (tgt_cmd != `CMD_SPECIAL);
      perr_pipe <= {perr_pipe[`PERR_DELAY_CYC-2:0], chk_pend && (par_calc != cpar_in)};
      cperr_b_out <= !perr_pipe[`PERR_DELAY_CYC-2];
      cperr_oe <= perr_pipe[`PERR_DELAY_CYC-2] || !cperr_b_out;
    end
  end

  // ----------------------------------------
  // Arbiter and lock
  // ----------------------------------------
  // Lock held by the bridge keeps the card off the bus
  always @(posedge clk) begin
    if (!rst_b) begin
      cgnt_b <= 1'b1;
      lock_held <= 1'b0;
      cblock_b_out <= 1'b1;
      cblock_oe <= 1'b0;
    end else if (ce) begin
      if (creq_b) begin
        cgnt_b <= 1'b1;
      end else if (bus_idle && !ini_busy && !ini_start && !lock_held) begin
        cgnt_b <= 1'b0;
      end
      if (ini_state == `I_DATA && ini_lock && cblock_b_in) begin
        lock_held <= 1'b1;
      end else if (!ini_lock && !ini_busy) begin
        lock_held <= 1'b0;
      end
      cblock_b_out <= !lock_held;
      cblock_oe <= lock_held || !cblock_b_out;
    end
  end

  // ----------------------------------------
  // Card events and sensing
  // ----------------------------------------
  // Slow release of system error is never taken as a new event
  always @(posedge clk) begin
    if (!rst_b) begin
      cserr_q <= 1'b1;
      stschg_q <= 1'b0;
      serr_b <= 1'b1;
      card_irq <= 1'b0;
      speaker_out <= 1'b0;
      stschg_alert <= 1'b0;
      wake_req <= 1'b0;
      card_present <= 1'b0;
      card_volt <= 2'h0;
      card_is_cardbus <= 1'b0;
      cvs1_out <= 1'b0;
      cvs1_oe <= 1'b0;
      cvs2_out <= 1'b0;
      cvs2_oe <= 1'b0;
    end else if (ce) begin
      cserr_q <= cserr_b;
      serr_b <= !(cserr_q && !cserr_b);
      card_irq <= !cint_b;
      speaker_out <= caudio;
      stschg_q <= cstschg;
      stschg_alert <= cstschg && !stschg_q;
      wake_req <= cstschg;
      // Both detects low means a card is seated
      card_present <= !ccd1_b && !ccd2_b;
      card_volt <= (!ccd1_b && !ccd2_b) ? {cvs2_in, cvs1_in} : 2'h0;
      card_is_cardbus <= (ccd1_b != ccd2_b) && (cvs1_in != cvs2_in);
    end
  end
endmodule // cardbus_socket_control
`default_nettype wire

// ==== sim/cardbus_socket_control_props.sv ====
// Checker for the pin and event relations of the socket control block.
// Assumes one clock, clk, and the bind at the foot of this file.
`timescale 1ns/1ns
`default_nettype none
module sock_ctl_props (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Card side inputs
  input wire caudio,
  input wire cint_b,
  input wire cstschg,
  input wire cserr_b,
  input wire creq_b,
  input wire cframe_b_in,
  input wire cirdy_b_in,
  input wire ctrdy_b_in,
  input wire cdevsel_b_in,
  // Driven pins and host outputs
  input wire cad_oe,
  input wire [31:0] cad_out,
  input wire [3:0] cbe_out,
  input wire cpar_out,
  input wire ini_done,
  input wire ini_abort,
  input wire cgnt_b,
  input wire serr_b,
  input wire speaker_out,
  input wire card_irq,
  input wire wake_req,
  input wire stschg_alert,
  input wire card_present,
  input wire [1:0] card_volt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------
  // Sideband outputs, one register each
  // ----------------------------------------
  AST_SPK: assert property ($past(rst_b) |-> speaker_out == $past(caudio))
    else $error("speaker output does not follow card audio");
  AST_IRQ: assert property ($past(rst_b) |-> card_irq == !$past(cint_b))
    else $error("interrupt level wrong");
  AST_WAKE: assert property ($past(rst_b) |-> wake_req == $past(cstschg))
    else $error("wake request wrong");
  AST_ALERT: assert property ($rose(cstschg) |=> stschg_alert)
    else $error("status change alert missing");
  AST_VOLT: assert property (!card_present |-> card_volt == 2'h0)
    else $error("voltage reported without a card");

  // ----------------------------------------
  // System error and arbitration
  // ----------------------------------------
  AST_SERR_ON: assert property ($fell(cserr_b) |-> ##[1:2] !serr_b)
    else $error("card system error not forwarded");
  // A slow release must not stretch the pulse past one cycle
  AST_SERR_PULSE: assert property (!serr_b |=> serr_b)
    else $error("host system error longer than one cycle");
  AST_GNT_ON: assert property ($fell(cgnt_b) |-> $past(!creq_b && cframe_b_in))
    else $error("grant without request or on a busy bus");
  AST_GNT_OFF: assert property ($rose(creq_b) |=> cgnt_b)
    else $error("grant kept after request dropped");

  // ----------------------------------------
  // Initiator transfers
  // ----------------------------------------
  AST_DONE: assert property (ini_done |-> $past(!cirdy_b_in && !ctrdy_b_in && !cdevsel_b_in))
    else $error("done without a completed data phase");
  AST_ABORT: assert property (ini_abort |-> $past(cdevsel_b_in, 1) && $past(cdevsel_b_in, 3))
    else $error("abort although a target claimed");
  AST_PAR: assert property ($past(cad_oe) |-> cpar_out == ^{$past(cad_out), $past(cbe_out)})
    else $error("parity output wrong");

  CV_DONE: cover property (ini_done);
  CV_ABORT: cover property (ini_abort);
  CV_GNT: cover property (!cgnt_b);
  CV_SERR: cover property (!serr_b);
endmodule // sock_ctl_props

bind cardbus_socket_control sock_ctl_props chk_u (.clk(clk), .rst_b(rst_b), .caudio(caudio),
  .cint_b(cint_b), .cstschg(cstschg), .cserr_b(cserr_b), .creq_b(creq_b),
  .cframe_b_in(cframe_b_in), .cirdy_b_in(cirdy_b_in), .ctrdy_b_in(ctrdy_b_in),
  .cdevsel_b_in(cdevsel_b_in), .cad_oe(cad_oe), .cad_out(cad_out), .cbe_out(cbe_out),
  .cpar_out(cpar_out), .ini_done(ini_done), .ini_abort(ini_abort), .cgnt_b(cgnt_b),
  .serr_b(serr_b), .speaker_out(speaker_out), .card_irq(card_irq), .wake_req(wake_req),
  .stschg_alert(stschg_alert), .card_present(card_present), .card_volt(card_volt));
`default_nettype wire

// ==== sim/card_model.sv ====
// Behavioural card answering as target to the bridge's transactions.
// Assumes resolved frame and ready lines; its device select and target ready idle high like pull-ups.
`timescale 1ns/1ns
`default_nettype none
module card_model (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Socket lines as resolved
  input wire frame_b,
  input wire irdy_b,
  // Behaviour chosen by the bench
  input wire claim,
  input wire [1:0] waits,
  // Target lines
  output reg devsel_b,
  output reg trdy_b,
  output reg [31:0] cad
);
  reg prev_frame;
  reg act;
  reg [1:0] cnt;
  // Claim on frame fall, insert waits, release after the final phase
  always @(posedge clk) begin
    prev_frame <= frame_b;
    cad <= {cad[30:0], ~cad[31]}; // Never a stale value on the data lines
    if (!rst_b) begin
      act <= 1'b0;
      devsel_b <= 1'b1;
      trdy_b <= 1'b1;
      cnt <= 2'h0;
      cad <= 32'h0f0f3c3c;
    end else if (!act) begin
      if (prev_frame && !frame_b && claim) begin
        act <= 1'b1;
        devsel_b <= 1'b0;
        cnt <= waits;
      end
    end else if (!irdy_b && !trdy_b) begin
      trdy_b <= (waits != 2'h0) || frame_b; // Zero waits keeps ready up between phases
      cnt <= waits;
      if (frame_b) begin
        act <= 1'b0;
        devsel_b <= 1'b1;
      end
    end else if (cnt != 2'h0) begin
      cnt <= cnt - 2'h1;
    end else begin
      trdy_b <= 1'b0;
    end
  end
endmodule // card_model
`default_nettype wire

// ==== sim/cardbus_socket_control_test.sv ====
// Testbench for the socket control block with a card model on the socket.
// Assumes the checker is bound to the design by its own file.
`timescale 1ns/1ns
`default_nettype none
module cardbus_socket_control_test;
  reg clk = 0, rst_b = 0, ini_start = 0, wd_valid = 0, creq_b = 1, cserr_b = 1, cint_b = 1;
  reg caudio = 0, cstschg = 0, ccd1_b = 1, ccd2_b = 1, cvs1 = 0, cvs2 = 0;
  reg tgt_ready = 0, tgt_disconnect = 0, m_claim = 1;
  reg [1:0] m_waits = 0;
  reg [3:0] ini_cmd = 0;
  reg [31:0] ini_addr = 0;
  reg [36:0] wd_data = 0;
  reg [31:0] exp_d [0:7];
  reg pa, pi, ps;
  integer n_errors = 0, n_checks = 0, i, k, n, t;
  wire [31:0] cad_out, m_cad;
  wire [3:0] cbe_out;
  wire cad_oe, cbe_oe, cpar_out, cpar_oe, fr_o, fr_e, ir_o, ir_e, tr_o, tr_e, dv_o, dv_e;
  wire st_o, st_e, pe_o, pe_e, lk_o, lk_e, m_dev, m_trdy, ini_done, ini_abort, wd_ready;
  wire cgnt_b, serr_b, card_irq, speaker_out, wake_req, card_is_cardbus;
  // Released lines: card model on target ready, device select and data, pull-ups on other control, inverse of last value on the rest
  wire fr = fr_e ? fr_o : 1'b1;
  wire ir = ir_e ? ir_o : 1'b1;
  wire tr = tr_e ? tr_o : m_trdy;
  wire dv = dv_e ? dv_o : m_dev;

  always #50 clk = ~clk;

  cardbus_socket_control dut_u (.clk(clk), .rst_b(rst_b), .ce(1'b1), .ini_start(ini_start),
    .ini_cmd(ini_cmd), .ini_addr(ini_addr), .ini_write(1'b1), .ini_lock(1'b0), .ini_busy(),
    .ini_done(ini_done), .ini_abort(ini_abort), .ini_stopped(), .wd_valid(wd_valid),
    .wd_ready(wd_ready), .wd_data(wd_data), .rd_valid(), .rd_data(), .tgt_hit(1'b0),
    .tgt_ready(tgt_ready), .tgt_disconnect(tgt_disconnect), .tgt_active(),
    .cad_in(cad_oe ? cad_out : m_cad), .cad_out(cad_out), .cad_oe(cad_oe),
    .cbe_in(cbe_oe ? cbe_out : ~cbe_out), .cbe_out(cbe_out), .cbe_oe(cbe_oe),
    .cpar_in(cpar_oe ? cpar_out : ~cpar_out), .cpar_out(cpar_out), .cpar_oe(cpar_oe),
    .cframe_b_in(fr), .cframe_b_out(fr_o), .cframe_oe(fr_e), .cirdy_b_in(ir),
    .cirdy_b_out(ir_o), .cirdy_oe(ir_e), .ctrdy_b_in(tr), .ctrdy_b_out(tr_o), .ctrdy_oe(tr_e),
    .cdevsel_b_in(dv), .cdevsel_b_out(dv_o), .cdevsel_oe(dv_e), .cstop_b_in(st_e ? st_o : 1'b1),
    .cstop_b_out(st_o), .cstop_oe(st_e), .cperr_b_in(pe_e ? pe_o : 1'b1), .cperr_b_out(pe_o),
    .cperr_oe(pe_e), .cblock_b_in(lk_e ? lk_o : 1'b1), .cblock_b_out(lk_o), .cblock_oe(lk_e),
    .creq_b(creq_b), .cgnt_b(cgnt_b), .cserr_b(cserr_b), .cint_b(cint_b), .caudio(caudio),
    .cstschg(cstschg), .ccd1_b(ccd1_b), .ccd2_b(ccd2_b), .cvs1_in(cvs1), .cvs1_out(),
    .cvs1_oe(), .cvs2_in(cvs2), .cvs2_out(), .cvs2_oe(), .serr_b(serr_b), .card_irq(card_irq),
    .speaker_out(speaker_out), .stschg_alert(), .wake_req(wake_req), .card_present(),
    .card_volt(), .card_is_cardbus(card_is_cardbus));

  card_model card_u (.clk(clk), .rst_b(rst_b), .frame_b(fr), .irdy_b(ir), .claim(m_claim),
    .waits(m_waits), .devsel_b(m_dev), .trdy_b(m_trdy), .cad(m_cad));

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task chk(input [36:0] seen, input [36:0] exp, input [8*12-1:0] what);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("mismatch %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // Every completed data phase must carry the next queued word
  always @(posedge clk) begin
    if (ir_e === 1'b1 && ir === 1'b0 && tr === 1'b0 && dv === 1'b0) begin
      chk(cad_out, exp_d[k[2:0]], "data");
      chk(cbe_out, 4'h0, "be");
      chk(fr, k[2:0] == 3'h7, "frame");
      k = k + 1;
    end
  end

  // A full run takes far less than this span
  initial begin
    #(4000 * 100);
    n_errors = n_errors + 1;
    report_and_stop;
  end

  task push(input [36:0] w);
    begin
      wd_valid <= 1'b1;
      wd_data <= w;
      do @(posedge clk); while (wd_ready !== 1'b1);
    end
  endtask

  task start(input [31:0] a);
    begin
      ini_addr <= a;
      ini_cmd <= 4'h7;
      ini_start <= 1'b1;
      @(posedge clk);
      ini_start <= 1'b0;
      @(posedge clk);
      chk(cad_out, a, "address");
      chk({fr_e, fr_o, cbe_out}, 6'h27, "command");
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    n = $urandom(32'hca679e62);
    k = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    // Fill the FIFO until it refuses, then drain it: zero-wait card, then a stalling one
    for (t = 0; t < 2; t = t + 1) begin
      for (i = 0; i < 8; i = i + 1) begin
        exp_d[i] = $urandom;
        push({i == 7, 4'h0, exp_d[i]});
      end
      wd_data <= 37'h0;
      @(posedge clk);
      chk(wd_ready, 1'b0, "full");
      wd_valid <= 1'b0;
      m_waits <= (t == 0) ? 2'h0 : n[1:0];
      start($urandom);
      for (i = 0; i < 200 && ini_done !== 1'b1; i = i + 1) @(posedge clk);
      chk(k, 8 * t + 8, "phases");
      $display("test burst done");
    end
    // No claim: the initiator must give up
    repeat (3) @(posedge clk);
    m_claim <= 1'b0;
    push({1'b1, 4'h0, 32'h0});
    wd_valid <= 1'b0;
    start(32'h00001000);
    for (i = 0; i < 20 && ini_abort !== 1'b1; i = i + 1) @(posedge clk);
    chk(ini_abort, 1'b1, "abort");
    chk(k, 16, "phases");
    $display("test abort done");
    // Grant follows the card's request on an idle bus
    repeat (4) @(posedge clk);
    creq_b <= 1'b0;
    repeat (3) @(posedge clk);
    chk(cgnt_b, 1'b0, "grant");
    creq_b <= 1'b1;
    repeat (3) @(posedge clk);
    chk(cgnt_b, 1'b1, "grant");
    $display("test grant done");
    // One error with a slow release gives exactly one host pulse
    cserr_b <= 1'b0;
    n = 0;
    for (i = 0; i < 12; i = i + 1) begin
      @(posedge clk);
      if (i == 5) cserr_b <= 1'b1;
      if (serr_b === 1'b0) n = n + 1;
    end
    chk(n, 1, "serr");
    $display("test serr done");
    // Random sideband levels, each compared one edge later
    @(posedge clk);
    for (i = 0; i < 40; i = i + 1) begin
      pa = caudio;
      pi = cint_b;
      ps = cstschg;
      n = $urandom;
      {caudio, cint_b, cstschg, ccd1_b, ccd2_b, cvs1, cvs2} <= n[6:0];
      tgt_ready <= n[7];
      tgt_disconnect <= n[8];
      @(posedge clk);
      chk(speaker_out, pa, "audio");
      chk(card_irq, !pi, "irq");
      chk(wake_req, ps, "wake");
      @(posedge clk);
      chk(card_is_cardbus, (ccd1_b ^ ccd2_b) & (cvs1 ^ cvs2), "card type");
    end
    $display("test sideband done");
    report_and_stop;
  end
endmodule // cardbus_socket_control_test
`default_nettype wire
